// ==== src/asp_pkg.sv ====
package asec_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_MHZ         = 250;
	localparam int PAGE_PROG_US    = 500;
	localparam int SECT_ERASE_US   = 100000;
	localparam int UNLOCK_DELAY_US = 100;
	localparam int UNLOCK_TOL_US   = 20;
	localparam int PAGE_CYC        = PAGE_PROG_US * CLK_MHZ;
	localparam int SECT_CYC        = SECT_ERASE_US * CLK_MHZ;
	localparam int UNLOCK_CYC      = UNLOCK_DELAY_US * CLK_MHZ;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam int AW = 8;
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_OPND_LO = 8'h04;
	localparam logic [7:0] OFF_OPND_HI = 8'h08;
	localparam logic [7:0] OFF_STATUS  = 8'h0c;
	localparam logic [7:0] OFF_MODE    = 8'h10;
	localparam logic [7:0] OFF_PWD_LO  = 8'h14;
	localparam logic [7:0] OFF_PWD_HI  = 8'h18;
	localparam logic [7:0] OFF_PERS    = 8'h1c;
	localparam logic [7:0] OFF_DYN     = 8'h20;
	localparam logic [7:0] OFF_PROT    = 8'h24;

	// ==========================================================
	// Field positions
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_SEC_LSB = 8;
	localparam int ST_ACTIVE   = 0;
	localparam int ST_ERR      = 1;
	localparam int ST_LOCK     = 2;
	localparam int ST_PWDMODE  = 3;
	localparam int MODE_LSB    = 1;

	// ==========================================================
	// Protection mode encodings
	localparam logic [1:0] MODE_UNSEL = 2'h3;
	localparam logic [1:0] MODE_PERS  = 2'h2;
	localparam logic [1:0] MODE_PWD   = 2'h1;
	localparam logic [1:0] MODE_BAD   = 2'h0;

	// ==========================================================
	// Reset values and bus responses
	localparam logic [63:0] PWD_RST     = 64'hffffffffffffffff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ==========================================================
	// Command codes
	localparam logic [3:0] OP_PERS_PROG  = 4'h1;
	localparam logic [3:0] OP_PERS_ERASE = 4'h2;
	localparam logic [3:0] OP_DYN_CLR    = 4'h3;
	localparam logic [3:0] OP_DYN_SET    = 4'h4;
	localparam logic [3:0] OP_LOCK_CLR   = 4'h5;
	localparam logic [3:0] OP_MODE_PROG  = 4'h6;
	localparam logic [3:0] OP_PWD_PROG   = 4'h7;
	localparam logic [3:0] OP_PWD_UNLOCK = 4'h8;
	localparam logic [3:0] OP_CLR_ERR    = 4'h9;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_BUSY
	} asec_state_t;

endpackage

// ==== src/asp_core.sv ====
// Overview of operation
// - Block-protect OR sector protection protects sector
// - Persistent or dynamic bit zero blocks changes
// - Lock zero freezes persistent bits, one permits
// - Persistent commands fail while lock is zero
// - Persistent mode: resets set lock, soft keeps
// - Lock-clear clears lock; only a reset or unlock sets it again
// - Password mode: resets clear lock; unlock sets
// - Mode bits decode; programming 00 is error
// - Mode register writable once, never erased
// - Mode programming busy one page time
// - Program bits singly, erase all together
// - Status readable; page or sector busy time
// - Dynamic bit written anytime, gated by persistent
// - All resets return dynamic bits to one
// - Password 64 bits, ones new, only clears
// - Password read/program ignored in password mode
// - Wrong password: error, busy stays, lock kept
// - Unlock attempts spaced 100 us; match no delay
// - Read protection forces boot sector reads
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module asec_core
	import asec_pkg::*;
#(
	parameter int          NS         = 32,
	parameter int          RAW        = 32,
	parameter logic [31:0] BOOT_ADDR  = 32'h00000000,
	parameter int unsigned PAGE_T     = PAGE_CYC,
	parameter int unsigned SECT_T     = SECT_CYC,
	parameter int unsigned UNLOCK_T   = UNLOCK_CYC
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              hw_reset,
	input  wire logic              sw_reset,

	// AXI4-Lite slave
	input  wire logic [31:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [31:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,

	// Block-protect range, decoded per sector
	input  wire logic [NS-1:0]     block_protect_field,

	// Array program/erase request
	input  wire logic              pe_req,
	input  wire logic [$clog2(NS)-1:0] pe_sector,
	output logic                   pe_accept,
	output logic                   pe_reject,

	// Read path
	input  wire logic              read_protect_mode,
	input  wire logic [RAW-1:0]    rd_addr_in,
	input  wire logic [1:0]        ecc_status_in,
	output logic [RAW-1:0]         rd_addr_out,
	output logic [1:0]             ecc_status_out,

	// Status
	output logic                   write_in_progress,
	output logic                   program_error,
	output logic                   persistent_bits_lock,
	output logic [NS-1:0]          sector_protected
);

	localparam int SW = $clog2(NS);

	// All state lives in one record, registered once per cycle
	typedef struct packed {
		asec_state_t    st;
		logic [3:0]     op;
		logic [SW-1:0]  sec;
		logic [31:0]    cnt;
		logic [31:0]    ugap;
		logic [NS-1:0]  persistent_sector_bit;
		logic [NS-1:0]  dynamic_sector_bit;
		logic [NS-1:0]  prot;
		logic           lock;
		logic           err;
		logic [1:0]     mode;
		logic [63:0]    pwd;
		logic [63:0]    opnd;
		logic           aw_got;
		logic           w_got;
		logic [AW-1:0]  awa;
		logic [31:0]    wd;
		logic [3:0]     ws;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		logic           pe_acc;
		logic           pe_rej;
		logic [RAW-1:0] rda;
		logic [1:0]     ecc;
	} asec_regs_t;

	asec_regs_t     q;
	asec_regs_t     n;
	logic [NS-1:0]  prot_c;
	logic           cmd_go;
	logic [3:0]     cmd_op;
	logic [SW-1:0]  cmd_sec;
	logic           nv_ok;
	logic           pwd_mode;
	logic [AW-1:0]  ara;

	// Byte-lane merge for the operand words
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
	                                      input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Protection combine
	// A sector is guarded if any of the three sources guards it
	assign prot_c   = block_protect_field | ~q.persistent_sector_bit
	                  | ~q.dynamic_sector_bit;
	assign pwd_mode = (q.mode == MODE_PWD);
	// Only word offsets are decoded; upper address bits alias
	assign ara      = {s_axi_araddr[AW-1:2], 2'b00};

	// ==========================================================
	// Next state
	always_comb begin
		n       = q;
		cmd_go  = 1'b0;
		cmd_op  = q.wd[CMD_OP_LSB +: 4];
		cmd_sec = q.wd[CMD_SEC_LSB +: SW];
		nv_ok   = (q.st == ST_IDLE) && !q.err;
		n.pe_acc = 1'b0;
		n.pe_rej = 1'b0;

		// Read channel
		// Address is taken whenever no read data is waiting
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !q.rvalid) begin
			n.rvalid = 1'b1;
			n.rresp  = RESP_OKAY;
			n.rdata  = 32'h00000000;
			case (ara)
				OFF_CMD: begin
				end
				OFF_OPND_LO: n.rdata = q.opnd[31:0];
				OFF_OPND_HI: n.rdata = q.opnd[63:32];
				OFF_STATUS: begin
					n.rdata[ST_ACTIVE]  = q.st == ST_BUSY || q.err;
					n.rdata[ST_ERR]     = q.err;
					n.rdata[ST_LOCK]    = q.lock;
					n.rdata[ST_PWDMODE] = pwd_mode;
				end
				OFF_MODE: n.rdata[MODE_LSB +: 2] = q.mode;
				OFF_PWD_LO: n.rdata = pwd_mode ? 32'h00000000 : q.pwd[31:0];
				OFF_PWD_HI: n.rdata = pwd_mode ? 32'h00000000 : q.pwd[63:32];
				OFF_PERS: n.rdata = 32'(q.persistent_sector_bit);
				OFF_DYN: n.rdata = 32'(q.dynamic_sector_bit);
				OFF_PROT: n.rdata = 32'(q.prot);
				default: n.rresp = RESP_SLVERR;
			endcase
		end

		// Write channels, taken in either order
		// A captured half waits for its partner; both readies stay low
		// until the response has been taken
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.awa    = {s_axi_awaddr[AW-1:2], 2'b00};
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.wd    = s_axi_wdata;
			n.ws    = s_axi_wstrb;
		end
		if (q.aw_got && q.w_got) begin
			n.aw_got = 1'b0;
			n.w_got  = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = RESP_OKAY;
			case (q.awa)
				OFF_CMD: cmd_go = q.ws[0];
				OFF_OPND_LO: n.opnd[31:0] = merge(q.opnd[31:0], q.wd, q.ws);
				OFF_OPND_HI: n.opnd[63:32] = merge(q.opnd[63:32], q.wd, q.ws);
				OFF_STATUS, OFF_MODE, OFF_PWD_LO, OFF_PWD_HI,
				OFF_PERS, OFF_DYN, OFF_PROT: begin
				end
				default: n.bresp = RESP_SLVERR;
			endcase
		end

		// Timed nonvolatile operation
		// The result lands only when the count runs out, so an aborted
		// operation leaves the nonvolatile bits untouched
		if (q.st == ST_BUSY) begin
			if (q.cnt == 32'h00000000) begin
				n.st = ST_IDLE;
				case (q.op)
					OP_PERS_PROG: n.persistent_sector_bit[q.sec] = 1'b0;
					OP_PERS_ERASE: n.persistent_sector_bit = '1;
					OP_MODE_PROG: n.mode = q.opnd[MODE_LSB +: 2];
					OP_PWD_PROG: n.pwd = q.pwd & q.opnd;
					default: begin
					end
				endcase
			end else begin
				n.cnt = q.cnt - 32'h00000001;
			end
		end

		// Unlock spacing outlives soft and hard resets, so a reset cannot
		// be used to hurry the next password guess
		if (q.ugap != 32'h00000000) begin
			n.ugap = q.ugap - 32'h00000001;
		end

		// Command execution
		// Only one nonvolatile operation at a time; a pending error
		// blocks new ones until software or a reset clears it
		if (cmd_go) begin
			case (cmd_op)
				OP_DYN_CLR: n.dynamic_sector_bit[cmd_sec] = 1'b0;
				OP_DYN_SET: n.dynamic_sector_bit[cmd_sec] = 1'b1;
				OP_CLR_ERR: n.err = 1'b0;
				OP_LOCK_CLR: begin
					if (nv_ok) begin
						n.lock = 1'b0;
					end
				end
				OP_PERS_PROG, OP_PERS_ERASE: begin
					if (nv_ok) begin
						if (!q.lock) begin
							n.err = 1'b1;
						end else begin
							n.st  = ST_BUSY;
							n.op  = cmd_op;
							n.sec = cmd_sec;
							n.cnt = (cmd_op == OP_PERS_PROG) ? 32'(PAGE_T - 1)
							        : 32'(SECT_T - 1);
						end
					end
				end
				OP_MODE_PROG: begin
					if (nv_ok) begin
						if (q.mode != MODE_UNSEL
						    || q.opnd[MODE_LSB +: 2] == MODE_BAD) begin
							n.err = 1'b1;
						end else begin
							n.st  = ST_BUSY;
							n.op  = cmd_op;
							n.cnt = 32'(PAGE_T - 1);
						end
					end
				end
				OP_PWD_PROG: begin
					if (nv_ok && !pwd_mode) begin
						n.st  = ST_BUSY;
						n.op  = cmd_op;
						n.cnt = 32'(PAGE_T - 1);
					end
				end
				OP_PWD_UNLOCK: begin
					if (nv_ok && pwd_mode && q.ugap == 32'h00000000) begin
						if (q.opnd == q.pwd) begin
							n.lock = 1'b1;
						end else begin
							n.err = 1'b1;
							n.st  = ST_BUSY;
							n.op  = cmd_op;
							n.cnt = 32'(UNLOCK_T - 1);
							n.ugap = 32'(UNLOCK_T - 1);
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Software and hardware reset
		// Nonvolatile bits and the mode survive both resets
		if (sw_reset || hw_reset) begin
			n.dynamic_sector_bit = '1;
			n.st  = ST_IDLE;
			n.err = 1'b0;
		end
		if (hw_reset) begin
			n.lock = !pwd_mode;
		end

		// Array program/erase check; a reject wins over a clear
		// Decided on the state held before this edge
		if (pe_req) begin
			if (prot_c[pe_sector]) begin
				n.pe_rej = 1'b1;
				n.err    = 1'b1;
			end else begin
				n.pe_acc = 1'b1;
			end
		end

		n.prot = block_protect_field | ~n.persistent_sector_bit
		         | ~n.dynamic_sector_bit;
		n.rda  = read_protect_mode ? BOOT_ADDR[RAW-1:0] : rd_addr_in;
		n.ecc  = ecc_status_in;
	end

	// ==========================================================
	// State register
	// Power-on reset models a fresh part: factory bits and mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.persistent_sector_bit <= '1;
			q.dynamic_sector_bit <= '1;
			q.lock <= 1'b1;
			q.mode <= MODE_UNSEL;
			q.pwd <= PWD_RST;
		end else begin
			q <= n;
		end
	end

	// ==========================================================
	// Outputs
	assign s_axi_awready        = !q.aw_got && !q.bvalid;
	assign s_axi_wready         = !q.w_got && !q.bvalid;
	assign s_axi_bvalid         = q.bvalid;
	assign s_axi_bresp          = q.bresp;
	assign s_axi_arready        = !q.rvalid;
	assign s_axi_rvalid         = q.rvalid;
	assign s_axi_rdata          = q.rdata;
	assign s_axi_rresp          = q.rresp;
	assign pe_accept            = q.pe_acc;
	assign pe_reject            = q.pe_rej;
	assign rd_addr_out          = q.rda;
	assign ecc_status_out       = q.ecc;
	// Busy is also shown while an error waits to be cleared
	assign write_in_progress    = (q.st == ST_BUSY) || q.err;
	assign program_error        = q.err;
	assign persistent_bits_lock = q.lock;
	assign sector_protected     = q.prot;

endmodule

`default_nettype wire

// ==== verif/asp_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Protection checker
module asec_monitor
	import asec_pkg::*;
#(
	parameter int          NS        = 32,
	parameter int          RAW       = 32,
	parameter logic [31:0] BOOT_ADDR = 32'h00000000
) (
	// Clock and resets
	input wire logic                  core_clk,
	input wire logic                  rst_n,
	input wire logic                  hw_reset,
	// Bus
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [1:0]            s_axi_bresp,
	// Array requests
	input wire logic [NS-1:0]         block_protect_field,
	input wire logic                  pe_req,
	input wire logic [$clog2(NS)-1:0] pe_sector,
	input wire logic                  pe_accept,
	input wire logic                  pe_reject,
	// Read path
	input wire logic                  read_protect_mode,
	input wire logic [RAW-1:0]        rd_addr_in,
	input wire logic [1:0]            ecc_status_in,
	input wire logic [RAW-1:0]        rd_addr_out,
	input wire logic [1:0]            ecc_status_out,
	// Status
	input wire logic                  write_in_progress,
	input wire logic                  program_error,
	input wire logic                  persistent_bits_lock,
	input wire logic [NS-1:0]         sector_protected
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Assertions
	prot_or_a: assert property ($past(rst_n) |->
		(sector_protected & $past(block_protect_field)) == $past(block_protect_field))
		else $error("block protect lost");
	blk_reject_a: assert property (pe_req && block_protect_field[pe_sector]
		|=> pe_reject && !pe_accept) else $error("protected sector not rejected");
	rej_err_a: assert property (pe_reject |-> program_error)
		else $error("reject without error");
	one_answer_a: assert property (pe_accept |-> $past(pe_req) && !pe_reject)
		else $error("bad accept");
	err_busy_a: assert property (program_error |-> write_in_progress)
		else $error("error without busy");
	lock_set_a: assert property ($rose(persistent_bits_lock)
		|-> $past(hw_reset) || $rose(s_axi_bvalid)) else $error("lock set by itself");
	rd_force_a: assert property (read_protect_mode |=> rd_addr_out == BOOT_ADDR)
		else $error("read not forced");
	rd_pass_a: assert property (!read_protect_mode
		|=> rd_addr_out == $past(rd_addr_in)) else $error("read address lost");
	ecc_pass_a: assert property (1'b1 |=> ecc_status_out == $past(ecc_status_in))
		else $error("ecc status lost");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");

	cover property (pe_reject);
	cover property ($rose(persistent_bits_lock));
	cover property (program_error ##1 !program_error);
	cover property ($fell(persistent_bits_lock));
endmodule
`default_nettype wire

// ==== verif/asp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Bus master of the host controller
module asec_host (
	input  wire logic        core_clk,
	// Write side
	output logic [31:0]      s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// Read side
	output logic [31:0]      s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic [31:0] s_axi_rdata,
	output logic             s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
	end
	// Handshakes are sampled mid-cycle, where they equal their edge value
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic h, g, b;
		@(posedge core_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge core_clk);
			h = s_axi_awready;
			g = s_axi_wready;
			b = s_axi_bvalid;
			@(posedge core_clk);
			if (h) s_axi_awvalid <= 1'b0;
			if (g) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic h, b;
		@(posedge core_clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge core_clk);
			h = s_axi_arready;
			b = s_axi_rvalid;
			d = s_axi_rdata;
			@(posedge core_clk);
			if (h) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== verif/asp_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module asec_core_tb;
	import asec_pkg::*;
	logic        core_clk = 0, rst_n = 0, hw_reset = 0, sw_reset = 0;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ecc_status_in = 0, ecc_status_out;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] block_protect_field = 0, rd_addr_in = 0, rd_addr_out, sector_protected;
	logic [4:0]  pe_sector = 0;
	logic        pe_req = 0, pe_accept, pe_reject, read_protect_mode = 0;
	logic        write_in_progress, program_error, persistent_bits_lock;
	logic [34:0] rq[$];
	logic [1:0]  pq[$];
	logic [34:0] e;
	int          errors = 0, check_count = 0;

	always #2 core_clk = ~core_clk;
	asec_core #(.PAGE_T(40), .SECT_T(80), .UNLOCK_T(60)) i_dut (.core_clk, .rst_n, .hw_reset,
		.sw_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.block_protect_field, .pe_req, .pe_sector, .pe_accept, .pe_reject, .read_protect_mode,
		.rd_addr_in, .ecc_status_in, .rd_addr_out, .ecc_status_out, .write_in_progress,
		.program_error, .persistent_bits_lock, .sector_protected);
	asec_host i_host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready);

	task automatic chk(input logic [33:0] s, input logic [33:0] x);
		check_count++;
		if (s !== x) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic ck(input logic [7:0] a, input logic [33:0] x);
		logic [31:0] d;
		rq.push_back({1'b1, x});
		i_host.rd(a, d);
	endtask
	task automatic cmd(input logic [3:0] op, input logic [4:0] s);
		i_host.wr(OFF_CMD, {19'h0, s, 4'h0, op});
	endtask
	task automatic idle;
		logic [31:0] d;
		d = 32'h1;
		for (int n = 0; n < 100 && d[ST_ACTIVE]; n++) begin
			rq.push_back(35'h0);
			i_host.rd(OFF_STATUS, d);
		end
		chk({33'h0, d[ST_ACTIVE]}, 34'h0);
	endtask
	task automatic pe(input logic [4:0] s, input logic [1:0] x);
		@(posedge core_clk);
		pe_req <= 1'b1;
		pe_sector <= s;
		pq.push_back(x);
		@(posedge core_clk);
		pe_req <= 1'b0;
	endtask
	task automatic pulse(input logic h);
		@(posedge core_clk);
		if (h) hw_reset <= 1'b1;
		else sw_reset <= 1'b1;
		@(posedge core_clk);
		hw_reset <= 1'b0;
		sw_reset <= 1'b0;
	endtask

	// ==========================================
	// Result watcher and random read path
	always @(posedge core_clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = rq.pop_front();
			if (e[34]) chk({s_axi_rresp, s_axi_rdata}, e[33:0]);
		end
		if (pe_accept || pe_reject) chk({32'h0, pe_accept, pe_reject}, {32'h0, pq.pop_front()});
		if (rst_n) begin
			read_protect_mode <= 1'($urandom);
			rd_addr_in <= $urandom;
			ecc_status_in <= 2'($urandom);
		end
	end
	initial begin
		#200000;
		errors++;
		final_report();
	end

	// ==========================================
	// Tests
	initial begin
		logic [31:0] r, pl, ph;
		logic [4:0]  s;
		r = $urandom(32'hd6e7);
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		ck(OFF_STATUS, 34'h4);
		ck(OFF_MODE, 34'h6);
		ck(OFF_PWD_HI, {2'b0, PWD_RST[63:32]});
		ck(OFF_DYN, 34'hffffffff);
		ck(8'h30, {RESP_SLVERR, 32'h0});
		$display("reset test done");
		r = ($urandom | 32'h1) & 32'hfffffffd;
		@(posedge core_clk);
		block_protect_field <= r;
		for (int i = 0; i < 4; i++) pe(i[4:0], {~r[i], r[i]});
		ck(OFF_PROT, {2'b0, r});
		chk({2'b0, sector_protected}, {2'b0, r});
		ck(OFF_STATUS, 34'h7);
		cmd(OP_CLR_ERR, 5'h0);
		block_protect_field <= 32'h0;
		$display("block test done");
		s = 5'($urandom);
		cmd(OP_DYN_CLR, s);
		ck(OFF_PROT, {2'b0, 32'h1 << s});
		pe(s, 2'b01);
		cmd(OP_CLR_ERR, 5'h0);
		cmd(OP_DYN_SET, s);
		pe(s, 2'b10);
		$display("dynamic test done");
		cmd(OP_PERS_PROG, s);
		ck(OFF_STATUS, 34'h5);
		idle();
		ck(OFF_PERS, {2'b0, ~(32'h1 << s)});
		pe(s, 2'b01);
		cmd(OP_CLR_ERR, 5'h0);
		cmd(OP_PERS_ERASE, 5'h0);
		idle();
		ck(OFF_PERS, 34'hffffffff);
		cmd(OP_LOCK_CLR, 5'h0);
		ck(OFF_STATUS, 34'h0);
		cmd(OP_PERS_PROG, s);
		ck(OFF_STATUS, 34'h3);
		ck(OFF_PERS, 34'hffffffff);
		cmd(OP_DYN_CLR, s);
		pulse(1'b0);
		ck(OFF_DYN, 34'hffffffff);
		ck(OFF_STATUS, 34'h0);
		pulse(1'b1);
		ck(OFF_STATUS, 34'h4);
		$display("persistent test done");
		pl = $urandom;
		ph = $urandom;
		i_host.wr(OFF_OPND_LO, pl);
		i_host.wr(OFF_OPND_HI, ph);
		cmd(OP_PWD_PROG, 5'h0);
		idle();
		i_host.wr(OFF_OPND_HI, 32'hffffffff);
		cmd(OP_PWD_PROG, 5'h0);
		idle();
		ck(OFF_PWD_HI, {2'b0, ph});
		i_host.wr(OFF_OPND_LO, 32'h0);
		cmd(OP_MODE_PROG, 5'h0);
		ck(OFF_MODE, 34'h6);
		cmd(OP_CLR_ERR, 5'h0);
		idle();
		i_host.wr(OFF_OPND_LO, 32'h2);
		cmd(OP_MODE_PROG, 5'h0);
		ck(OFF_STATUS, 34'h5);
		idle();
		ck(OFF_PWD_LO, 34'h0);
		pulse(1'b1);
		ck(OFF_STATUS, 34'h8);
		i_host.wr(OFF_OPND_LO, 32'h4);
		cmd(OP_MODE_PROG, 5'h0);
		ck(OFF_MODE, 34'h2);
		cmd(OP_CLR_ERR, 5'h0);
		idle();
		i_host.wr(OFF_OPND_HI, ph);
		i_host.wr(OFF_OPND_LO, ~pl);
		cmd(OP_PWD_UNLOCK, 5'h0);
		ck(OFF_STATUS, 34'hb);
		cmd(OP_CLR_ERR, 5'h0);
		ck(OFF_STATUS, 34'h9);
		pulse(1'b0);
		i_host.wr(OFF_OPND_LO, pl);
		cmd(OP_PWD_UNLOCK, 5'h0);
		ck(OFF_STATUS, 34'h8);
		repeat (64) @(posedge core_clk);
		idle();
		i_host.wr(OFF_OPND_LO, pl);
		cmd(OP_PWD_UNLOCK, 5'h0);
		ck(OFF_STATUS, 34'hc);
		chk({31'h0, write_in_progress, program_error, persistent_bits_lock}, 34'h1);
		$display("password test done");
		final_report();
	end
endmodule

bind asec_core asec_monitor #(.NS(NS), .RAW(RAW), .BOOT_ADDR(BOOT_ADDR)) i_mon (.core_clk,
	.rst_n, .hw_reset, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .block_protect_field, .pe_req,
	.pe_sector, .pe_accept, .pe_reject, .read_protect_mode, .rd_addr_in, .ecc_status_in,
	.rd_addr_out, .ecc_status_out, .write_in_progress, .program_error, .persistent_bits_lock,
	.sector_protected);
`default_nettype wire
